/* File: verilog/fscs_pkg.sv */
// Package for the fuse, signature and configuration store
package fscs_pkg;
   // Variant selection for page geometry
   typedef enum logic [1:0] {
      FSCS_VAR_8K  = 2'b00,
      FSCS_VAR_16K = 2'b01,
      FSCS_VAR_32K = 2'b11
   } fscs_variant_t;

   // Byte-select read source encoding {byte_select_high, byte_select_low}
   localparam logic [1:0] SEL_LOW_BYTE  = 2'h0;
   localparam logic [1:0] SEL_LOCK_BITS = 2'h1;
   localparam logic [1:0] SEL_EXT_BYTE  = 2'h2;
   localparam logic [1:0] SEL_HIGH_BYTE = 2'h3;

   // Factory values; a 0 is a programmed fuse
   localparam logic [7:0] EXT_RESET     = 8'hFF;
   localparam logic [7:0] EXT_USED_MASK = 8'h07;
   localparam logic [7:0] HIGH_RESET    = 8'h99;
   localparam logic [7:0] LOW_RESET     = 8'h62;
   localparam logic [7:0] LOCK_RESET    = 8'hFF;

   // Field positions
   localparam int HIGH_DEBUG_BIT    = 7;
   localparam int HIGH_SCAN_BIT     = 6;
   localparam int HIGH_SERIAL_BIT   = 5;
   localparam int HIGH_WATCHDOG_BIT = 4;
   localparam int HIGH_PRESERVE_BIT = 3;
   localparam int HIGH_BOOT_MSB     = 2;
   localparam int HIGH_BOOT_LSB     = 1;
   localparam int HIGH_VECTOR_BIT   = 0;
   localparam int LOW_DIV8_BIT      = 7;
   localparam int LOW_CLKOUT_BIT    = 6;
   localparam int LOW_SUT_MSB       = 5;
   localparam int LOW_SUT_LSB       = 4;
   localparam int LOW_CKSRC_MSB     = 3;
   localparam int LOCK_FIRST_BIT    = 0;

   // Signature address space
   localparam logic [1:0] SIG_ADDR_0 = 2'h0;
   localparam logic [1:0] SIG_ADDR_1 = 2'h1;
   localparam logic [1:0] SIG_ADDR_2 = 2'h2;

   // Page geometry
   localparam int PC_WIDTH       = 15;
   localparam int EEA_WIDTH      = 11;
   localparam int PAGE_BITS_SML  = 6;
   localparam int PAGE_BITS_BIG  = 7;
   localparam int EE_BITS_SML    = 2;
   localparam int EE_BITS_BIG    = 3;

   // Working configuration carried to the rest of the device
   typedef struct packed {
      logic [2:0] brownout_level;
      logic       onchip_debug_enable;
      logic       boundary_scan_enable;
      logic       serial_download_enable;
      logic       watchdog_always_on;
      logic       data_mem_preserve;
      logic [1:0] boot_size;
      logic       reset_vector_select;
      logic       clock_divide_by_eight;
      logic       clock_output_enable;
      logic [1:0] startup_time;
      logic [3:0] clock_source;
   } fscs_cfg_t;
endpackage

/* File: verilog/fscs_store.sv */
// Fuse bytes, signature, calibration copy and page geometry store
`timescale 1ns/1ps
module fscs_store
   import fscs_pkg::*;
#(
   parameter logic [7:0] SIG_BYTE0 = 8'h5A, // Arbitrary identity value
   parameter logic [7:0] SIG_BYTE1 = 8'h11, // Arbitrary identity value
   parameter logic [7:0] SIG_BYTE2 = 8'h22, // Arbitrary identity value
   parameter logic [7:0] CAL_BYTE  = 8'h80, // Arbitrary trim value
   parameter fscs_variant_t VARIANT = FSCS_VAR_32K
) (
   input  wire logic                 clk,             // System clock
   input  wire logic                 rstn,            // Async reset, active low
   input  wire logic                 prog_mode,       // Programming mode active
   input  wire logic                 serial_path,     // Access comes from serial path
   input  wire logic                 fuse_wr,         // Fuse write strobe
   input  wire logic                 fuse_rd,         // Fuse or lock read strobe
   input  wire logic                 sig_rd,          // Signature read strobe
   input  wire logic                 cal_rd,          // Calibration read strobe
   input  wire logic                 byte_select_high,// Byte select high
   input  wire logic                 byte_select_low, // Byte select low
   input  wire logic [1:0]           sig_addr,        // Signature address
   input  wire logic [7:0]           wr_data,         // Write data
   input  wire logic                 chip_erase,      // Chip erase pulse
   input  wire logic [7:0]           lock_bits,       // Current lock bits
   input  wire logic                 sleeping,        // Device in sleep mode
   input  wire logic [PC_WIDTH-1:0]  pc_addr,         // Program counter
   input  wire logic [EEA_WIDTH-1:0] data_mem_address,// Data memory address
   output logic [7:0]                rd_data,         // Read data
   output logic                      rd_valid,        // Read data valid pulse
   output logic                      wr_refused,      // Fuse write refused pulse
   output fscs_cfg_t                 cfg,             // Working configuration
   output logic [7:0]                oscillator_trim_register, // Trim value
   output logic                      clk_out_en,      // Clock pin driven
   output logic                      sleep_clk_keep,  // Clock kept in sleep
   output logic [7:0]                page_word_index, // Program page word
   output logic [7:0]                page_number_index,// Program page number
   output logic [2:0]                data_page_offset,// Data page byte
   output logic [10:0]               data_page_number // Data page number
);
   logic [7:0] ext_q, high_q, low_q;
   logic       prog_mode_q, started_q;
   logic [1:0] sel;
   logic       locked;
   fscs_cfg_t  latch_d;
   // Page split widths of this variant, used only by the checks below
   localparam int WORD_BITS = (VARIANT == FSCS_VAR_32K) ? PAGE_BITS_BIG : PAGE_BITS_SML;
   localparam int DATA_BITS = (VARIANT == FSCS_VAR_32K) ? EE_BITS_BIG : EE_BITS_SML;

   assign sel    = {byte_select_high, byte_select_low};
   assign locked = ~lock_bits[LOCK_FIRST_BIT];

   // Nonvolatile fuse bytes; erase never touches them
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ext_q  <= EXT_RESET;
         high_q <= HIGH_RESET;
         low_q  <= LOW_RESET;
      end else if (fuse_wr && prog_mode && !locked) begin
         unique case (sel)
            SEL_LOW_BYTE: low_q <= wr_data;
            SEL_LOCK_BITS: high_q <= serial_path ?
               {wr_data[7:6], high_q[HIGH_SERIAL_BIT], wr_data[4:0]} : wr_data;
            SEL_EXT_BYTE: ext_q <= wr_data | ~EXT_USED_MASK;
            SEL_HIGH_BYTE: ; // Reserved slot, write ignored
         endcase
      end
   end

   // Refusal flag for a write blocked by the lock
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) wr_refused <= 1'b0;
      else wr_refused <= fuse_wr && prog_mode && locked;
   end

   // Working latch image of the stored bytes
   always_comb begin
      latch_d.brownout_level         = ext_q[2:0];
      latch_d.onchip_debug_enable    = high_q[HIGH_DEBUG_BIT];
      latch_d.boundary_scan_enable   = high_q[HIGH_SCAN_BIT];
      latch_d.serial_download_enable = high_q[HIGH_SERIAL_BIT];
      latch_d.watchdog_always_on     = high_q[HIGH_WATCHDOG_BIT];
      latch_d.data_mem_preserve      = high_q[HIGH_PRESERVE_BIT];
      latch_d.boot_size              = high_q[HIGH_BOOT_MSB:HIGH_BOOT_LSB];
      latch_d.reset_vector_select    = high_q[HIGH_VECTOR_BIT];
      latch_d.clock_divide_by_eight  = low_q[LOW_DIV8_BIT];
      latch_d.clock_output_enable    = low_q[LOW_CLKOUT_BIT];
      latch_d.startup_time           = low_q[LOW_SUT_MSB:LOW_SUT_LSB];
      latch_d.clock_source           = low_q[LOW_CKSRC_MSB:0];
   end

   // Mode edge tracking: first cycle after reset counts as power-up
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prog_mode_q <= 1'b0;
         started_q   <= 1'b0;
      end else begin
         prog_mode_q <= prog_mode;
         started_q   <= 1'b1;
      end
   end

   // Working latches: captured at power-up and on entry, frozen in mode except the preservation bit
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cfg <= fscs_cfg_t'({EXT_RESET[2:0], HIGH_RESET, LOW_RESET});
      end else if (!started_q) begin
         cfg <= latch_d;
      end else if (prog_mode && !prog_mode_q) begin
         cfg <= latch_d;
      end else if (!prog_mode) begin
         cfg <= latch_d; // Deferred changes land after exit
      end else begin
         // Preservation bit bypasses the freeze
         cfg.data_mem_preserve <= high_q[HIGH_PRESERVE_BIT];
      end
   end

   // Read mux; signature stays readable under lock
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_data  <= 8'hFF;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= fuse_rd || sig_rd || cal_rd;
         if (sig_rd) begin
            unique case (sig_addr)
               SIG_ADDR_0: rd_data <= SIG_BYTE0;
               SIG_ADDR_1: rd_data <= SIG_BYTE1;
               SIG_ADDR_2: rd_data <= SIG_BYTE2;
               default:    rd_data <= 8'hFF;
            endcase
         end else if (cal_rd) begin
            rd_data <= CAL_BYTE;
         end else if (fuse_rd) begin
            unique case (sel)
               SEL_LOW_BYTE:  rd_data <= low_q;
               SEL_LOCK_BITS: rd_data <= lock_bits;
               SEL_EXT_BYTE:  rd_data <= ext_q | ~EXT_USED_MASK;
               SEL_HIGH_BYTE: rd_data <= serial_path ?
                  (high_q | 8'h20) : high_q;
            endcase
         end
      end
   end

   // Trim register loaded while reset is held, as a constant
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) oscillator_trim_register <= CAL_BYTE;
   end

   // Clock output and sleep clock keep, active on a programmed fuse
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         clk_out_en     <= 1'b0;
         sleep_clk_keep <= 1'b0;
      end else begin
         clk_out_en     <= ~cfg.clock_output_enable;
         sleep_clk_keep <= sleeping & ~cfg.onchip_debug_enable;
      end
   end

   // Page geometry split by variant
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         page_word_index   <= 8'h00;
         page_number_index <= 8'h00;
         data_page_offset  <= 3'h0;
         data_page_number  <= 11'h000;
      end else if (VARIANT == FSCS_VAR_32K) begin
         page_word_index   <= {1'b0, pc_addr[PAGE_BITS_BIG-1:0]};
         page_number_index <= pc_addr[PC_WIDTH-1:PAGE_BITS_BIG];
         data_page_offset  <= data_mem_address[EE_BITS_BIG-1:0];
         data_page_number  <= {3'h0, data_mem_address[EEA_WIDTH-1:EE_BITS_BIG]};
      end else begin
         page_word_index   <= {2'h0, pc_addr[PAGE_BITS_SML-1:0]};
         page_number_index <= (VARIANT == FSCS_VAR_16K) ?
            pc_addr[13:PAGE_BITS_SML] : {1'b0, pc_addr[12:PAGE_BITS_SML]};
         data_page_offset  <= {1'b0, data_mem_address[EE_BITS_SML-1:0]};
         data_page_number  <= (VARIANT == FSCS_VAR_16K) ?
            {3'h0, data_mem_address[9:EE_BITS_SML]} : {4'h0, data_mem_address[8:EE_BITS_SML]};
      end
   end

   // Checks
   chk_lock_refuse: assert property (@(posedge clk) disable iff (!rstn)
      (fuse_wr && prog_mode && locked) |=> (wr_refused && $stable(high_q) && $stable(low_q)))
      else $error("fuse write under lock not refused");
   chk_mode_freeze: assert property (@(posedge clk) disable iff (!rstn)
      (prog_mode && prog_mode_q && started_q) |=> $stable(cfg.clock_source))
      else $error("working latch changed in programming mode");
   chk_preserve_live: assert property (@(posedge clk) disable iff (!rstn)
      started_q |=> cfg.data_mem_preserve == $past(high_q[HIGH_PRESERVE_BIT]))
      else $error("preserve fuse not immediate");
   chk_erase_keeps: assert property (@(posedge clk) disable iff (!rstn)
      (chip_erase && !fuse_wr) |=> $stable(low_q) && $stable(high_q) && $stable(ext_q))
      else $error("erase changed fuses");
   chk_ext_unused: assert property (@(posedge clk) disable iff (!rstn)
      ext_q[7:3] == 5'h1F)
      else $error("unused extended bits not one");
   chk_sig_read: assert property (@(posedge clk) disable iff (!rstn)
      (sig_rd && sig_addr == SIG_ADDR_0) |=> (rd_valid && rd_data == SIG_BYTE0))
      else $error("signature byte wrong");
   chk_serial_hide: assert property (@(posedge clk) disable iff (!rstn)
      (fuse_wr && prog_mode && !locked && serial_path && sel == SEL_LOCK_BITS)
      |=> $stable(high_q[HIGH_SERIAL_BIT]))
      else $error("serial path changed download fuse");
   chk_clk_out: assert property (@(posedge clk) disable iff (!rstn)
      started_q |=> clk_out_en == !$past(cfg.clock_output_enable))
      else $error("clock output not following fuse");
   chk_trim_hold: assert property (@(posedge clk) disable iff (!rstn)
      oscillator_trim_register == CAL_BYTE)
      else $error("trim register lost calibration");
   cov_write_ok: cover property (@(posedge clk) disable iff (!rstn)
      fuse_wr && prog_mode && !locked);
   cov_mode_enter: cover property (@(posedge clk) disable iff (!rstn)
      prog_mode && !prog_mode_q);
   cov_refused: cover property (@(posedge clk) disable iff (!rstn) wr_refused);
   cov_serial_write: cover property (@(posedge clk) disable iff (!rstn)
      fuse_wr && prog_mode && !locked && serial_path);
   cov_mode_exit: cover property (@(posedge clk) disable iff (!rstn)
      !prog_mode && prog_mode_q);

   // Write path: an accepted write lands one edge later, a refused or reserved one never
   chk_refuse_only_lock: assert property (@(posedge clk) disable iff (!rstn)
      !(fuse_wr && prog_mode && locked) |=> !wr_refused)
      else $error("write refusal without a lock");
   chk_low_write: assert property (@(posedge clk) disable iff (!rstn)
      (fuse_wr && prog_mode && !locked && sel == SEL_LOW_BYTE) |=> low_q == $past(wr_data))
      else $error("low byte write lost");
   chk_high_write: assert property (@(posedge clk) disable iff (!rstn)
      (fuse_wr && prog_mode && !locked && !serial_path && sel == SEL_LOCK_BITS)
      |=> high_q == $past(wr_data))
      else $error("high byte write lost");
   chk_reserved_write: assert property (@(posedge clk) disable iff (!rstn)
      (fuse_wr && sel == SEL_HIGH_BYTE) |=> $stable(low_q) && $stable(high_q) && $stable(ext_q))
      else $error("reserved select changed a fuse byte");

   // Read path; signature and calibration strobes win over a fuse read
   chk_valid_idle: assert property (@(posedge clk) disable iff (!rstn)
      !(fuse_rd || sig_rd || cal_rd) |=> !rd_valid)
      else $error("read valid without a strobe");
   chk_lock_read: assert property (@(posedge clk) disable iff (!rstn)
      (fuse_rd && !sig_rd && !cal_rd && sel == SEL_LOCK_BITS) |=> rd_data == $past(lock_bits))
      else $error("lock bits read wrong");
   chk_ext_read: assert property (@(posedge clk) disable iff (!rstn)
      (fuse_rd && !sig_rd && !cal_rd && sel == SEL_EXT_BYTE) |=> rd_data[7:3] == 5'h1F)
      else $error("unused extended bits read as zero");
   // A serial programmer must never see the download fuse as programmed
   chk_serial_read: assert property (@(posedge clk) disable iff (!rstn)
      (fuse_rd && !sig_rd && !cal_rd && serial_path && sel == SEL_HIGH_BYTE)
      |=> rd_data[HIGH_SERIAL_BIT] == 1'b1)
      else $error("serial read exposed download fuse");
   chk_sig_second: assert property (@(posedge clk) disable iff (!rstn)
      (sig_rd && sig_addr == SIG_ADDR_1) |=> (rd_valid && rd_data == SIG_BYTE1))
      else $error("second signature byte wrong");
   chk_sig_third: assert property (@(posedge clk) disable iff (!rstn)
      (sig_rd && sig_addr == SIG_ADDR_2) |=> (rd_valid && rd_data == SIG_BYTE2))
      else $error("third signature byte wrong");
   chk_cal_read: assert property (@(posedge clk) disable iff (!rstn)
      (cal_rd && !sig_rd) |=> (rd_valid && rd_data == CAL_BYTE))
      else $error("calibration byte read wrong");

   // Working latches: capture on entry, follow outside programming mode
   chk_entry_capture: assert property (@(posedge clk) disable iff (!rstn)
      (prog_mode && !prog_mode_q && started_q) |=> cfg.clock_source == $past(low_q[LOW_CKSRC_MSB:0]))
      else $error("latches not captured on entry");
   chk_exit_follow: assert property (@(posedge clk) disable iff (!rstn)
      !prog_mode |=> cfg.clock_source == $past(low_q[LOW_CKSRC_MSB:0]))
      else $error("latches not following fuses in normal mode");
   // Sleep clock keep costs power, so it must drop one cycle after the latched debug fuse is released
   chk_sleep_keep: assert property (@(posedge clk) disable iff (!rstn)
      started_q |=> sleep_clk_keep == ($past(sleeping) && !$past(cfg.onchip_debug_enable)))
      else $error("sleep clock keep not following debug fuse");

   // Page split: the low address bits pass through unchanged into the in-page index
   chk_page_word: assert property (@(posedge clk) disable iff (!rstn)
      started_q |=> page_word_index == 8'($past(pc_addr) & PC_WIDTH'((32'h1 << WORD_BITS) - 32'h1)))
      else $error("page word index wrong");
   chk_data_offset: assert property (@(posedge clk) disable iff (!rstn)
      started_q |=> data_page_offset == 3'($past(data_mem_address) & EEA_WIDTH'((32'h1 << DATA_BITS) - 32'h1)))
      else $error("data page offset wrong");
endmodule

/* File: sim/fscs_prog_model.sv */
// Programmer model driving the store's programming port
`timescale 1ns/1ps
module fscs_prog_model (
   input  wire logic       clk,         // System clock
   input  wire logic [7:0] rd_data,     // Read data from store
   input  wire logic       rd_valid,    // Read data valid
   output logic            prog_mode,   // Programming mode
   output logic            serial_path, // Serial access
   output logic            fuse_wr,     // Write strobe
   output logic            fuse_rd,     // Fuse read strobe
   output logic            sig_rd,      // Signature read strobe
   output logic            cal_rd,      // Calibration read strobe
   output logic [1:0]      sel,         // Byte selects, high then low
   output logic [1:0]      sig_addr,    // Signature address
   output logic [7:0]      wr_data      // Write data
);
   // Idle levels from time zero
   initial begin
      {prog_mode, serial_path, fuse_wr, fuse_rd, sig_rd, cal_rd} = 6'h00;
      sel = 2'h0;
      sig_addr = 2'h0;
      wr_data = 8'h00;
   end
   // Mode changes on a falling edge, away from the sampling edge
   task automatic mode(input logic pm, input logic ser);
      @(negedge clk);
      prog_mode = pm;
      serial_path = ser;
   endtask
   // Strobe is high across exactly one rising edge
   task automatic wr(input logic [1:0] s, input logic [7:0] d);
      @(negedge clk);
      sel = s;
      wr_data = d;
      fuse_wr = 1'b1;
      @(negedge clk);
      fuse_wr = 1'b0;
      wr_data = ~d; // Released data must not look like the last value
   endtask
   // Kind 0 fuse or lock, 1 signature, 2 calibration; bounded wait on valid
   task automatic rd(input int kind, input logic [1:0] a, output logic [7:0] d);
      int n;
      @(negedge clk);
      sel = a;
      sig_addr = a;
      fuse_rd = (kind == 0);
      sig_rd = (kind == 1);
      cal_rd = (kind == 2);
      @(negedge clk);
      {fuse_rd, sig_rd, cal_rd} = 3'h0;
      n = 0;
      while (rd_valid !== 1'b1 && n < 4) begin
         @(negedge clk);
         n++;
      end
      d = (rd_valid === 1'b1) ? rd_data : 8'hXX;
   endtask
endmodule

/* File: sim/fscs_store_tb_top.sv */
// Self-checking bench for the fuse, signature and configuration store
`timescale 1ns/1ps
module fscs_store_tb_top;
   import fscs_pkg::*;
   localparam logic [7:0] SIG0 = 8'hA1; // Arbitrary identity value
   localparam logic [7:0] SIG1 = 8'hB2; // Arbitrary identity value
   localparam logic [7:0] SIG2 = 8'hC3; // Arbitrary identity value
   localparam logic [7:0] CAL  = 8'h6D; // Arbitrary trim value
   logic clk, rstn, pm, ser, wr, frd, srd, crd, erase, sleeping, rv, refused, clko, keep;
   logic [1:0]  sel, sa;
   logic [7:0]  wd, lock, rdat, trim, pwi, pni, d;
   logic [14:0] pc;
   logic [10:0] eea, dpn;
   logic [2:0]  dpo;
   logic [7:0]  pwi8, pni8;
   logic [10:0] dpn8;
   logic [2:0]  dpo8;
   fscs_cfg_t   cfg;
   int          fails, num_checks;
   fscs_store #(.SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2), .CAL_BYTE(CAL), .VARIANT(FSCS_VAR_32K)) dut (
      .clk(clk), .rstn(rstn), .prog_mode(pm), .serial_path(ser), .fuse_wr(wr), .fuse_rd(frd), .sig_rd(srd),
      .cal_rd(crd), .byte_select_high(sel[1]), .byte_select_low(sel[0]), .sig_addr(sa), .wr_data(wd),
      .chip_erase(erase), .lock_bits(lock), .sleeping(sleeping), .pc_addr(pc), .data_mem_address(eea),
      .rd_data(rdat), .rd_valid(rv), .wr_refused(refused), .cfg(cfg), .oscillator_trim_register(trim),
      .clk_out_en(clko), .sleep_clk_keep(keep), .page_word_index(pwi), .page_number_index(pni),
      .data_page_offset(dpo), .data_page_number(dpn));
   fscs_prog_model prog (
      .clk(clk), .rd_data(rdat), .rd_valid(rv), .prog_mode(pm), .serial_path(ser), .fuse_wr(wr),
      .fuse_rd(frd), .sig_rd(srd), .cal_rd(crd), .sel(sel), .sig_addr(sa), .wr_data(wd));
   // Smallest variant shares all stimulus; only its page split is watched
   fscs_store #(.VARIANT(FSCS_VAR_8K)) dut_small (
      .clk(clk), .rstn(rstn), .prog_mode(pm), .serial_path(ser), .fuse_wr(wr), .fuse_rd(frd), .sig_rd(srd),
      .cal_rd(crd), .byte_select_high(sel[1]), .byte_select_low(sel[0]), .sig_addr(sa), .wr_data(wd),
      .chip_erase(erase), .lock_bits(lock), .sleeping(sleeping), .pc_addr(pc), .data_mem_address(eea),
      .rd_data(), .rd_valid(), .wr_refused(), .cfg(), .oscillator_trim_register(), .clk_out_en(),
      .sleep_clk_keep(), .page_word_index(pwi8), .page_number_index(pni8), .data_page_offset(dpo8),
      .data_page_number(dpn8));
   // Free-running 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Watchdog: the sequence needs well under a thousand cycles
   initial begin
      #200000;
      fails++;
      wrap_up();
   end
   // Main sequence
   initial begin
      fails = 0;
      num_checks = 0;
      rstn = 1'b0;
      {erase, sleeping} = 2'b00;
      lock = 8'hFF;
      pc = 15'h5ABC;
      eea = 11'h5AB;
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      repeat (3) @(negedge clk);
      // Factory bytes and power-up latching
      prog.rd(0, SEL_LOW_BYTE, d); chk(d, 16'h62);
      prog.rd(0, SEL_HIGH_BYTE, d); chk(d, 16'h99);
      prog.rd(0, SEL_EXT_BYTE, d); chk(d, 16'hFF);
      prog.rd(0, SEL_LOCK_BITS, d); chk(d, 16'hFF);
      chk({cfg.clock_divide_by_eight, cfg.clock_output_enable, cfg.startup_time, cfg.clock_source}, 16'h62);
      chk({cfg.brownout_level, cfg.boot_size, cfg.onchip_debug_enable}, 16'h39);
      chk(trim, CAL);
      chk(clko, 16'h0);
      // Page geometry of the largest variant
      chk(pwi, 16'h3C);
      chk(pni, 16'hB5);
      chk(dpo, 16'h3);
      chk(dpn, 16'hB5);
      // Page geometry of the smallest variant
      chk(pwi8, 16'h3C);
      chk(pni8, 16'h6A);
      chk(dpo8, 16'h3);
      chk(dpn8, 16'h6A);
      // Writes inside programming mode are deferred, except preservation
      prog.mode(1'b1, 1'b0);
      prog.wr(2'h0, 8'h22);
      prog.rd(0, SEL_LOW_BYTE, d); chk(d, 16'h22);
      chk({cfg.clock_divide_by_eight, cfg.clock_output_enable, cfg.startup_time, cfg.clock_source}, 16'h62);
      prog.wr(2'h1, 8'h11);
      repeat (2) @(negedge clk);
      chk(cfg.data_mem_preserve, 16'h0);
      chk(cfg.onchip_debug_enable, 16'h1);
      prog.rd(0, SEL_HIGH_BYTE, d); chk(d, 16'h11);
      // Unused positions and the reserved select
      prog.wr(2'h2, 8'h00);
      prog.rd(0, SEL_EXT_BYTE, d); chk(d, 16'hF8);
      prog.wr(2'h3, 8'h00);
      prog.rd(0, SEL_LOW_BYTE, d); chk(d, 16'h22);
      // Serial path cannot see or change the download fuse
      prog.mode(1'b1, 1'b1);
      prog.wr(2'h1, 8'h3F);
      prog.rd(0, SEL_HIGH_BYTE, d); chk(d, 16'h3F);
      prog.mode(1'b1, 1'b0);
      prog.rd(0, SEL_HIGH_BYTE, d); chk(d, 16'h1F);
      // Chip erase leaves fuses alone
      @(negedge clk);
      erase = 1'b1;
      @(negedge clk);
      erase = 1'b0;
      prog.rd(0, SEL_LOW_BYTE, d); chk(d, 16'h22);
      // Lock applied only after fuses are done
      lock = 8'hFE;
      prog.wr(2'h0, 8'hFF);
      chk(refused, 16'h1);
      prog.rd(0, SEL_LOW_BYTE, d); chk(d, 16'h22);
      prog.rd(1, SIG_ADDR_0, d); chk(d, SIG0);
      prog.rd(1, SIG_ADDR_1, d); chk(d, SIG1);
      prog.rd(1, SIG_ADDR_2, d); chk(d, SIG2);
      prog.rd(2, SIG_ADDR_0, d); chk(d, CAL);
      // Leaving programming mode applies the deferred values
      prog.mode(1'b0, 1'b0);
      repeat (3) @(negedge clk);
      chk({cfg.clock_divide_by_eight, cfg.clock_output_enable, cfg.startup_time, cfg.clock_source}, 16'h22);
      chk(clko, 16'h1);
      chk(keep, 16'h0);
      sleeping = 1'b1;
      repeat (3) @(negedge clk);
      chk(keep, 16'h1);
      wrap_up();
   end
endmodule
